// ### design/cesr_event_regs.sv
// How it works
// - watchdog expiry sets timer bit 3
// - usb session expiry sets timer bit 2
// - charge timer expiry sets timer bit 1
// - timer bit 0 mirrors first register pending
// - boost bus overload in boost sets boost bit 3
// - capacitor overload sets boost bit 2
// - bus overvoltage in boost sets bit 1
// - battery out of range sets bit 0
// - sense bit 7 shows input lockout live
// - sense bits 5,4 show usb range live
// - sense bit 3 shows input present live
// - sense bit 2 shows charger detect live
// - sense bit 1 shows bus low live
// - summary out reports any pending timer event
`timescale 1ns/1ps
`default_nettype none

module cesr_event_regs
    import cesr_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // register read port from the serial engine
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_rd_stb,
    output logic      [7:0] reg_rd_data,
    output logic            reg_rd_hit,
    // timer expiry pulses
    input  wire logic       watchdog_expire,
    input  wire logic       usb_session_expire,
    input  wire logic       charge_timer_expire,
    input  wire logic       watchdog_stop_bit,
    input  wire logic       charge_timer_stop_bit,
    // boost fault events
    input  wire logic       boost_bus_overload_evt,
    input  wire logic       boost_cap_overload_evt,
    input  wire logic       bus_overvoltage_evt,
    input  wire logic       battery_range_fault_evt,
    // live comparators
    input  wire logic       input_lockout_live,
    input  wire logic       input_above_usb_live,
    input  wire logic       input_below_usb_live,
    input  wire logic       input_present_live,
    input  wire logic       charger_detect_live,
    input  wire logic       boost_bus_low_live,
    // state and reset sources
    input  wire logic       register_soft_reset,
    input  wire logic       off_state,
    input  wire logic       timer_soft_reset,
    input  wire logic       boost_operation_state,
    input  wire logic       boost_startup_state,
    input  wire logic       charging_operation_state,
    // chained summaries
    input  wire logic       first_group_summary,
    output logic            second_group_summary
);

    // ======================================================================
    // flag and mode history registers
    logic [2:0] timer_flags_reg;
    logic [2:0] timer_flags_next;
    logic [3:0] boost_flags_reg;
    logic [3:0] boost_flags_next;
    logic       boost_mode_reg;
    logic       startup_reg;
    logic       charge_mode_reg;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic       rd_hit_reg;

    // ======================================================================
    // decode
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_addr);
        addr_is = (a == ref_addr);
    endfunction : addr_is

    wire rd_timer = reg_rd_stb && addr_is(reg_addr, CESR_ADDR_TIMER_EVT);
    wire rd_boost = reg_rd_stb && addr_is(reg_addr, CESR_ADDR_BOOST_EVT);
    wire rd_sense = reg_rd_stb && addr_is(reg_addr, CESR_ADDR_INPUT_SNS);

    // rising edges of the mode signals
    wire boost_entry   = boost_operation_state && !boost_mode_reg;
    wire startup_entry = boost_startup_state && !startup_reg;
    wire charge_entry  = charging_operation_state && !charge_mode_reg;

    wire timer_clear = off_state || register_soft_reset || timer_soft_reset || boost_entry;
    wire boost_clear = off_state || register_soft_reset || charge_entry;

    // stopped timers cannot raise expiry events
    wire [2:0] timer_set = {watchdog_expire && !watchdog_stop_bit,
                            usb_session_expire,
                            charge_timer_expire && !charge_timer_stop_bit};

    // bus overvoltage counts only during boost operation
    wire [3:0] boost_set = {boost_bus_overload_evt && boost_operation_state,
                            boost_cap_overload_evt,
                            bus_overvoltage_evt && boost_operation_state,
                            battery_range_fault_evt};

    // ======================================================================
    // read timing
    //   cycle 0: strobe and address stand; flags and live bits are
    //            captured into the answer register at the closing edge,
    //            and a timer or boost read clears its flags there
    //   cycle 1: answer and hit stand for exactly this cycle
    //   cycle 2: answer back to zero unless another read was taken
    // reads may follow back to back; each one sees the flags left by
    // the previous read plus whatever was set in between
    // the live comparators are not synchronised here: the comparator
    // side must present settled levels on this clock

    // ======================================================================
    // flag cell behaviour
    // each latched flag position is one cell with three inputs:
    //   hard clear - off state, register reset, timer reset (timer cells only) or a mode
    //                entry; it beats a set in the same cycle, so a flag
    //                never survives the event meant to wipe it
    //   set        - the gated event pulse from the timer or analog side
    //   soft clear - a host read of the register, and for the bus
    //                overload bit also entry to boost start-up; a set in
    //                the same cycle wins so a racing event is not lost
    // the read returns the value held before the clear, so the host sees
    // every flag not wiped by a hard clear or a start-up entry at least once
    function automatic logic flag_next(input logic cur,
                                       input logic set,
                                       input logic soft_clr,
                                       input logic hard_clr);
        if (hard_clr) begin
            flag_next = 1'b0;
        end else if (set) begin
            flag_next = 1'b1;
        end else if (soft_clr) begin
            flag_next = 1'b0;
        end else begin
            flag_next = cur;
        end
    endfunction : flag_next

    // ======================================================================
    // timer group clear vectors
    // read clears timer flags
    wire [2:0] timer_soft_clear = {3{rd_timer}};
    wire [2:0] timer_hard_clear = {3{timer_clear}};

    // ======================================================================
    // boost group clear vectors
    // read clears, start-up also clears the bus overload bit
    wire [3:0] boost_soft_clear = {rd_boost || startup_entry, {3{rd_boost}}};
    wire [3:0] boost_hard_clear = {4{boost_clear}};

    // ======================================================================
    // timer flag cells, one per expiry source
    genvar gi;
    for (gi = 0; gi < 3; gi++) begin : g_timer_cell
        assign timer_flags_next[gi] = flag_next(timer_flags_reg[gi],
                                                timer_set[gi],
                                                timer_soft_clear[gi],
                                                timer_hard_clear[gi]);
    end

    // ======================================================================
    // boost flag cells, one per fault source
    genvar gb;
    for (gb = 0; gb < 4; gb++) begin : g_boost_cell
        assign boost_flags_next[gb] = flag_next(boost_flags_reg[gb],
                                                boost_set[gb],
                                                boost_soft_clear[gb],
                                                boost_hard_clear[gb]);
    end

    // ======================================================================
    // named flag positions inside the flag vectors
    wire watchdog_expired_flag     = timer_flags_reg[2];
    wire usb_session_expired_flag  = timer_flags_reg[1];
    wire charge_timer_expired_flag = timer_flags_reg[0];
    wire boost_bus_overload_flag   = boost_flags_reg[3];
    wire boost_cap_overload_flag   = boost_flags_reg[2];
    wire bus_overvoltage_flag      = boost_flags_reg[1];
    wire battery_range_fault_flag  = boost_flags_reg[0];

    // ======================================================================
    // register views as the host sees them
    // timer view, summary in bit 0
    wire [7:0] timer_view = {4'h0,
                             watchdog_expired_flag,
                             usb_session_expired_flag,
                             charge_timer_expired_flag,
                             first_group_summary};
    wire [7:0] boost_view = {4'h0,
                             boost_bus_overload_flag,
                             boost_cap_overload_flag,
                             bus_overvoltage_flag,
                             battery_range_fault_flag};
    wire [7:0] sense_view = {input_lockout_live,
                             1'b0,
                             input_above_usb_live,
                             input_below_usb_live,
                             input_present_live,
                             charger_detect_live,
                             boost_bus_low_live,
                             1'b0};

    // ======================================================================
    // read data select; unmapped or idle returns zero
    assign rd_data_next = rd_timer ? timer_view :
                          rd_boost ? boost_view :
                          rd_sense ? sense_view : CESR_FLAG_RESET;

    // a mapped read raises the hit one cycle later
    wire rd_mapped = rd_timer || rd_boost || rd_sense;

    // ======================================================================
    // timer flag register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            timer_flags_reg <= 3'h0;
        end else begin
            timer_flags_reg <= timer_flags_next;
        end
    end

    // ======================================================================
    // boost flag register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            boost_flags_reg <= 4'h0;
        end else begin
            boost_flags_reg <= boost_flags_next;
        end
    end

    // ======================================================================
    // mode history for entry edge detection
    // these reset low, so a mode already high at release counts as an
    // entry and applies that entry's clear on the first edge, as after power-on
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            boost_mode_reg  <= 1'b0;
            startup_reg     <= 1'b0;
            charge_mode_reg <= 1'b0;
        end else begin
            boost_mode_reg  <= boost_operation_state;
            startup_reg     <= boost_startup_state;
            charge_mode_reg <= charging_operation_state;
        end
    end

    // ======================================================================
    // read answer, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data_reg <= CESR_FLAG_RESET;
            rd_hit_reg  <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_hit_reg  <= rd_mapped;
        end
    end

    // ======================================================================
    // outputs
    assign reg_rd_data = rd_data_reg;
    assign reg_rd_hit  = rd_hit_reg;

    // summary toward first charger register
    // combinational so the first register sees a new flag at once
    assign second_group_summary = watchdog_expired_flag
                                  || usb_session_expired_flag
                                  || charge_timer_expired_flag;

endmodule : cesr_event_regs

`default_nettype wire

// ### design/cesr_pkg.sv
package cesr_pkg;
    // ======================================================================
    // register offsets (8-bit register address space)
    localparam logic [7:0] CESR_ADDR_FIRST_CHG  = 8'h04;
    localparam logic [7:0] CESR_ADDR_TIMER_EVT  = 8'h05;
    localparam logic [7:0] CESR_ADDR_BOOST_EVT  = 8'h06;
    localparam logic [7:0] CESR_ADDR_INPUT_SNS  = 8'h07;

    // ======================================================================
    // timer event register fields
    localparam int CESR_TMR_WDOG_BIT   = 3;
    localparam int CESR_TMR_USB_BIT    = 2;
    localparam int CESR_TMR_CHG_BIT    = 1;
    localparam int CESR_TMR_SUM_BIT    = 0;

    // ======================================================================
    // boost event register fields
    localparam int CESR_BST_BUS_OL_BIT = 3;
    localparam int CESR_BST_CAP_OL_BIT = 2;
    localparam int CESR_BST_BUS_OV_BIT = 1;
    localparam int CESR_BST_VBAT_BIT   = 0;

    // ======================================================================
    // input sense register fields
    localparam int CESR_SNS_LOCKOUT_BIT = 7;
    localparam int CESR_SNS_USB_OV_BIT  = 5;
    localparam int CESR_SNS_USB_UV_BIT  = 4;
    localparam int CESR_SNS_PRESENT_BIT = 3;
    localparam int CESR_SNS_CHGDET_BIT  = 2;
    localparam int CESR_SNS_BUS_LOW_BIT = 1;

    // ======================================================================
    // reset values and timer lengths in seconds
    localparam logic [7:0] CESR_FLAG_RESET    = 8'h00;
    localparam int         CESR_WDOG_TIME_S   = 32;
    localparam int         CESR_USB_TIME_S    = 2048;
    localparam int         CESR_CHG_TIME_S    = 3600;
endpackage : cesr_pkg

// ### dv/cesr_event_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// read port and flag checks
module cesr_event_regs_props (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd_stb,
    input wire logic [7:0] reg_rd_data,
    input wire logic       reg_rd_hit,
    input wire logic       watchdog_expire,
    input wire logic       usb_session_expire,
    input wire logic       charge_timer_expire,
    input wire logic       watchdog_stop_bit,
    input wire logic       boost_bus_overload_evt,
    input wire logic       register_soft_reset,
    input wire logic       off_state,
    input wire logic       timer_soft_reset,
    input wire logic       boost_operation_state,
    input wire logic       boost_startup_state,
    input wire logic       charging_operation_state,
    input wire logic       first_group_summary,
    input wire logic       second_group_summary
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // boost overload raised, one quiet cycle, then read
    sequence bst_set;
        boost_bus_overload_evt && boost_operation_state && !off_state && !register_soft_reset
            && !charging_operation_state;
    endsequence
    sequence bst_quiet;
        !reg_rd_stb && !boost_startup_state && !charging_operation_state && !off_state && !register_soft_reset;
    endsequence
    wdog_sets_a: assert property (watchdog_expire && !watchdog_stop_bit && !off_state && !register_soft_reset
        && !timer_soft_reset && !boost_operation_state |=> second_group_summary) else $error("watchdog not latched");
    clear_wins_a: assert property ((off_state || register_soft_reset || timer_soft_reset)
        |=> !second_group_summary) else $error("summary survived clear");
    read_clears_a: assert property (reg_rd_stb && reg_addr == 8'h05 && !watchdog_expire && !usb_session_expire
        && !charge_timer_expire |=> !second_group_summary) else $error("read did not clear");
    chain_bit_a: assert property (reg_rd_stb && reg_addr == 8'h05
        |=> reg_rd_data[0] == $past(first_group_summary)) else $error("summary bit wrong");
    reserved_zero_a: assert property (reg_rd_stb && reg_addr inside {8'h05, 8'h06}
        |=> reg_rd_data[7:4] == 4'h0) else $error("reserved bits set");
    hit_mapped_a: assert property (reg_rd_stb && reg_addr inside {8'h05, 8'h06, 8'h07}
        |=> reg_rd_hit) else $error("no hit");
    miss_unmapped_a: assert property (reg_rd_stb && !(reg_addr inside {8'h05, 8'h06, 8'h07})
        |=> !reg_rd_hit && reg_rd_data == 8'h00) else $error("unmapped answered");
    idle_zero_a: assert property (!reg_rd_stb |=> !reg_rd_hit && reg_rd_data == 8'h00)
        else $error("data without read");
    bst_overload_a: assert property (bst_set ##1 bst_quiet ##1 (reg_rd_stb && reg_addr == 8'h06)
        |=> reg_rd_data[3]) else $error("overload flag lost");
endmodule : cesr_event_regs_props
bind cesr_event_regs cesr_event_regs_props u_props (.clk_sys, .rst_n, .reg_addr, .reg_rd_stb, .reg_rd_data,
    .reg_rd_hit, .watchdog_expire, .usb_session_expire, .charge_timer_expire, .watchdog_stop_bit,
    .boost_bus_overload_evt, .register_soft_reset, .off_state, .timer_soft_reset, .boost_operation_state,
    .boost_startup_state, .charging_operation_state, .first_group_summary, .second_group_summary);
`default_nettype wire

// ### dv/cesr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// host side of the register read port
module cesr_host_model (
    input  wire logic       clk_sys,
    output var logic  [7:0] reg_addr,
    output var logic        reg_rd_stb,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_hit
);
    initial begin
        reg_addr = 8'h00;
        reg_rd_stb = 1'b0;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(posedge clk_sys);
        #2;
        reg_addr = a;
        reg_rd_stb = 1'b1;
        @(posedge clk_sys);
        #2;
        d = reg_rd_data;
        h = reg_rd_hit;
        reg_rd_stb = 1'b0;
        reg_addr = ~a; // released address shows no stale value
    endtask : rd
endmodule : cesr_host_model
`default_nettype wire

// ### dv/test_charger_event_sense_regs.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// bench top
module test_charger_event_sense_regs;
    logic clk_sys, rst_n, first_group_summary;
    logic [2:0] tmr_ev, clr, mode;
    logic [3:0] bst_ev;
    logic [5:0] live;
    logic [1:0] stops;
    wire logic watchdog_expire, usb_session_expire, charge_timer_expire, watchdog_stop_bit, charge_timer_stop_bit;
    wire logic boost_bus_overload_evt, boost_cap_overload_evt, bus_overvoltage_evt, battery_range_fault_evt;
    wire logic input_lockout_live, input_above_usb_live, input_below_usb_live, input_present_live;
    wire logic charger_detect_live, boost_bus_low_live, register_soft_reset, off_state, timer_soft_reset;
    wire logic boost_operation_state, boost_startup_state, charging_operation_state, reg_rd_stb, reg_rd_hit;
    wire logic second_group_summary;
    wire logic [7:0] reg_addr, reg_rd_data;
    int n_errors = 0;
    int checks = 0;
    // grouped stimulus onto the single-bit inputs
    assign {watchdog_expire, usb_session_expire, charge_timer_expire} = tmr_ev;
    assign {boost_bus_overload_evt, boost_cap_overload_evt, bus_overvoltage_evt, battery_range_fault_evt} = bst_ev;
    assign {input_lockout_live, input_above_usb_live, input_below_usb_live, input_present_live, charger_detect_live,
        boost_bus_low_live} = live;
    assign {register_soft_reset, off_state, timer_soft_reset} = clr;
    assign {boost_operation_state, boost_startup_state, charging_operation_state} = mode;
    assign {watchdog_stop_bit, charge_timer_stop_bit} = stops;
    cesr_event_regs u_dut (.clk_sys, .rst_n, .reg_addr, .reg_rd_stb, .reg_rd_data, .reg_rd_hit, .watchdog_expire,
        .usb_session_expire, .charge_timer_expire, .watchdog_stop_bit, .charge_timer_stop_bit, .boost_bus_overload_evt,
        .boost_cap_overload_evt, .bus_overvoltage_evt, .battery_range_fault_evt, .input_lockout_live,
        .input_above_usb_live, .input_below_usb_live, .input_present_live, .charger_detect_live, .boost_bus_low_live,
        .register_soft_reset, .off_state, .timer_soft_reset, .boost_operation_state, .boost_startup_state,
        .charging_operation_state, .first_group_summary, .second_group_summary);
    cesr_host_model u_host (.clk_sys, .reg_addr, .reg_rd_stb, .reg_rd_data, .reg_rd_hit);
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic step;
        @(posedge clk_sys);
        #2;
    endtask : step
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
        end
    endtask : cmp1
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       h;
        u_host.rd(a, d, h);
        cmp8(d, exp);
        cmp1(h, a inside {8'h05, 8'h06, 8'h07});
    endtask : rdchk
    task automatic complete_run;
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    // watchdog against a hung read
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end
    // main sequence
    initial begin
        {rst_n, first_group_summary, tmr_ev, clr, mode, bst_ev, live, stops} = '0;
        repeat (16) step();
        rst_n = 1'b1;
        rdchk(8'h05, 8'h00);
        rdchk(8'h06, 8'h00);
        tmr_ev = 3'b111;
        first_group_summary = 1'b1;
        step();
        tmr_ev = 3'b000;
        cmp1(second_group_summary, 1'b1);
        rdchk(8'h05, 8'h0f);
        rdchk(8'h05, 8'h01);
        first_group_summary = 1'b0;
        stops = 2'b11;
        tmr_ev = 3'b111;
        step();
        {tmr_ev, stops} = '0;
        rdchk(8'h05, 8'h04);
        for (int i = 0; i < 4; i++) begin
            tmr_ev = 3'b111;
            step();
            tmr_ev = 3'b000;
            if (i < 3) clr = 3'b001 << i;
            else mode = 3'b100;
            step();
            clr = 3'b000;
            rdchk(8'h05, 8'h00);
        end
        bst_ev = 4'hf;
        step();
        bst_ev = 4'h0;
        rdchk(8'h06, 8'h0f);
        rdchk(8'h06, 8'h00);
        bst_ev = 4'hc;
        step();
        {bst_ev, mode} = {4'h0, 3'b110};
        step();
        rdchk(8'h06, 8'h04);
        bst_ev = 4'hf;
        step();
        {bst_ev, mode} = {4'h0, 3'b001};
        step();
        rdchk(8'h06, 8'h00);
        bst_ev = 4'hf;
        step();
        bst_ev = 4'h0;
        rdchk(8'h06, 8'h05);
        for (int i = 0; i < 6; i++) begin
            live = 6'h01 << i;
            rdchk(8'h07, {live[5], 1'b0, live[4:0], 1'b0});
        end
        rdchk(8'h04, 8'h00);
        rdchk(8'hff, 8'h00);
        complete_run();
    end
endmodule : test_charger_event_sense_regs
`default_nettype wire
